// ---- rtl/clkgen_regs_pkg.sv ----
// Register map, field layout and sequencing constants of the holdover delay and soft reset slice
package clkgen_regs_pkg;

    typedef logic [11:0] reg_idx_t;

    // Register indices; the byte address on the bus is four times the index
    localparam reg_idx_t IDX_HIST_DLY_B3 = 12'h284;
    localparam reg_idx_t IDX_HIST_DLY_B2 = 12'h285;
    localparam reg_idx_t IDX_HIST_DLY_B1 = 12'h286;
    localparam reg_idx_t IDX_HIST_DLY_B0 = 12'h287;
    localparam reg_idx_t IDX_CHAN_RST = 12'h2A4;
    localparam reg_idx_t IDX_PLL_RST = 12'h2A5;

    // Reserved registers with their writable bit masks
    localparam int unsigned RSVD_NUM = 15;
    localparam reg_idx_t RSVD_IDX [RSVD_NUM] = '{
        12'h2A6, 12'h2A9, 12'h2AA, 12'h2AB, 12'h2AC, 12'h2AD, 12'h2AE, 12'h2AF,
        12'h2B0, 12'h2B3, 12'h2CB, 12'h2CC, 12'h2CD, 12'h2CE, 12'h2CF
    };
    localparam logic [7:0] RSVD_WMASK [RSVD_NUM] = '{
        8'hE0, 8'h77, 8'hF7, 8'h77, 8'h77, 8'h77, 8'h77, 8'h07,
        8'h77, 8'hFF, 8'h0F, 8'h84, 8'h84, 8'h84, 8'h84
    };

    // Field layout
    localparam logic [7:0] HIST_DLY_B3_WMASK = 8'h7F;
    localparam int unsigned CHAN_RST_W = 6;
    localparam int unsigned PLL1_RST_BIT = 0;
    localparam int unsigned PLL2_RST_BIT = 1;
    localparam int unsigned NUM_OUT_DIV = 8;

    // Values after reset
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [CHAN_RST_W-1:0] CHAN_RST_RESET = 6'h00;

    // Channel codes
    localparam logic [CHAN_RST_W-1:0] CHAN_CODE_CH0 = 6'h00;
    localparam logic [CHAN_RST_W-1:0] CHAN_CODE_CH1 = 6'h01;
    localparam logic [CHAN_RST_W-1:0] CHAN_CODE_CH23 = 6'h02;
    localparam logic [CHAN_RST_W-1:0] CHAN_CODE_CH45 = 6'h03;
    localparam logic [CHAN_RST_W-1:0] CHAN_CODE_CH6 = 6'h04;
    localparam logic [CHAN_RST_W-1:0] CHAN_CODE_CH7 = 6'h05;

    // Soft reset pulse length in core clock cycles
    localparam logic [3:0] SOFT_RST_PULSE_CYCLES = 4'h4;

    // AHB-Lite transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef enum logic [1:0] {
        STB_IDLE = 2'b00,
        STB_PULSE = 2'b01,
        STB_CLEAR = 2'b10
    } strobe_state_e;

endpackage : clkgen_regs_pkg

// ---- rtl/reset_strobe_seq.sv ----
// Sequencer that turns a trigger into a reset pulse lasting SOFT_RST_PULSE_CYCLES cycles after the last trigger, followed by a clear strobe
`timescale 1ns/100ps
module reset_strobe_seq
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Trigger
    input wire logic i_start,
    // Results
    output logic o_pulse,
    output logic o_done
);
    import clkgen_regs_pkg::*;

    typedef struct packed {
        strobe_state_e state;
        logic [3:0] cnt;
        logic pulse;
        logic done;
    } seq_s;

    seq_s q;
    seq_s d;

    always_comb
    begin
        d = q;
        d.done = 1'b0;
        unique case (q.state)
            STB_IDLE:
            begin
                if (i_start)
                begin
                    d.state = STB_PULSE;
                    d.cnt = SOFT_RST_PULSE_CYCLES - 4'h1;
                    d.pulse = 1'b1;
                end
            end
            STB_PULSE:
            begin
                if (i_start)
                begin
                    d.cnt = SOFT_RST_PULSE_CYCLES - 4'h1;
                end
                else if (q.cnt == 4'h0)
                begin
                    d.state = STB_CLEAR;
                    d.pulse = 1'b0;
                end
                else
                begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            STB_CLEAR:
            begin
                // A fresh trigger here restarts the pulse and cancels the clear
                if (i_start)
                begin
                    d.state = STB_PULSE;
                    d.cnt = SOFT_RST_PULSE_CYCLES - 4'h1;
                    d.pulse = 1'b1;
                end
                else
                begin
                    d.state = STB_IDLE;
                    d.done = 1'b1;
                end
            end
            default:
            begin
                d.state = STB_IDLE;
                d.pulse = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q <= '{state: STB_IDLE, cnt: 4'h0, pulse: 1'b0, done: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign o_pulse = q.pulse;
    assign o_done = q.done;

endmodule : reset_strobe_seq

// ---- rtl/holdover_delay_and_soft_reset_regs.sv ----
// AHB-Lite register slice: second loop history delay and self-clearing soft reset controls
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
//
// Function
// R1: Delay bytes assemble bits 30:24, 23:16, 15:8, 7:0 from lowest to highest address.
// R2: First delay byte bit 7 is reserved read-only; bits 6:0 hold delay 30:24.
// R3: Software keeps the delay below two to the power of the history timer.
// R4: Software keeps the history timer setting between 0 and 30.
// R5: Channel field code selects divider: 0,1,2-3,4-5,6,7 for codes 0 to 5.
// R6: Channel field resets to zero, write triggers, self clears; bits 7:6 read zero.
// R7: Bit 1 of PLL reset resets second PLL calibrator, N, R and VCO dividers.
// R8: After second PLL soft reset its calibrator owns the N divider reset.
// R9: Bit 0 resets first PLL calibrator and dividers; calibrator then owns N reset.
// R10: Each PLL soft reset bit returns to zero by itself.
// R11: PLL soft reset leaves the CMOS output divider untouched.
// R12: PLL reset register bits 7:2 are reserved, read-only, zero.
// R13: Valid channel write gives one reset pulse then field clears within cycles.
// R14: Software writes back reserved fields as read.
module holdover_delay_and_soft_reset_regs
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // Second loop history monitor setting
    output logic [30:0] o_second_loop_history_delay,
    // Output channel divider resets
    output logic [clkgen_regs_pkg::NUM_OUT_DIV-1:0] o_out_div_rst,
    // PLL resets, index 0 first PLL, index 1 second PLL
    output logic [1:0] o_pll_cal_rst,
    output logic [1:0] o_pll_ndiv_rst,
    output logic [1:0] o_pll_rdiv_rst,
    output logic [1:0] o_pll_vcodiv_rst,
    output logic [1:0] o_pll_ndiv_cal_own
);
    import clkgen_regs_pkg::*;

    // Register selected by an index
    typedef enum logic [2:0] {
        KIND_NONE = 3'b000,
        KIND_DLY_B3 = 3'b001,
        KIND_DLY_B2 = 3'b010,
        KIND_DLY_B1 = 3'b011,
        KIND_DLY_B0 = 3'b100,
        KIND_CHAN = 3'b101,
        KIND_PLL = 3'b110,
        KIND_RSVD = 3'b111
    } reg_kind_e;

    typedef struct packed {
        logic wr_pend;
        reg_idx_t wr_idx;
        logic wr_map;
        logic [31:0] rdata;
        logic [7:0] dly_b3;
        logic [7:0] dly_b2;
        logic [7:0] dly_b1;
        logic [7:0] dly_b0;
        logic [CHAN_RST_W-1:0] chan_field;
        logic [1:0] pll_field;
        logic [RSVD_NUM-1:0][7:0] rsvd;
        logic [NUM_OUT_DIV-1:0] out_div_rst;
        logic [1:0] pll_rst;
        logic [1:0] ndiv_own;
    } regs_s;

    regs_s q;
    regs_s d;

    logic addr_ok;
    reg_kind_e wr_kind;
    logic access;
    reg_idx_t acc_idx;
    logic wr_now;
    logic chan_start;
    logic [1:0] pll_start;
    logic chan_pulse;
    logic chan_done;
    logic [1:0] pll_pulse;
    logic [1:0] pll_done;

    // Channel code to divider mask; codes above the table select nothing
    function automatic logic [NUM_OUT_DIV-1:0] chan_decode(input logic [CHAN_RST_W-1:0] code);
        logic [NUM_OUT_DIV-1:0] m;
        m = '0;
        unique case (code)
            CHAN_CODE_CH0: m = 8'h01;
            CHAN_CODE_CH1: m = 8'h02;
            CHAN_CODE_CH23: m = 8'h0C;
            CHAN_CODE_CH45: m = 8'h30;
            CHAN_CODE_CH6: m = 8'h40;
            CHAN_CODE_CH7: m = 8'h80;
            default: m = 8'h00;
        endcase
        return m; // [R5]
    endfunction : chan_decode

    // Index of a reserved register, or RSVD_NUM when none matches
    function automatic int unsigned rsvd_slot(input reg_idx_t idx);
        int unsigned s;
        s = RSVD_NUM;
        for (int unsigned i = 0; i < RSVD_NUM; i++)
        begin
            if (RSVD_IDX[i] == idx)
            begin
                s = i;
            end
        end
        return s;
    endfunction : rsvd_slot

    // One index decode, shared by map check, read view and write commit
    function automatic reg_kind_e reg_kind(input reg_idx_t idx);
        reg_kind_e k;
        unique case (idx)
            IDX_HIST_DLY_B3: k = KIND_DLY_B3;
            IDX_HIST_DLY_B2: k = KIND_DLY_B2;
            IDX_HIST_DLY_B1: k = KIND_DLY_B1;
            IDX_HIST_DLY_B0: k = KIND_DLY_B0;
            IDX_CHAN_RST: k = KIND_CHAN;
            IDX_PLL_RST: k = KIND_PLL;
            default: k = (rsvd_slot(idx) != RSVD_NUM) ? KIND_RSVD : KIND_NONE;
        endcase
        return k;
    endfunction : reg_kind

    function automatic logic is_mapped(input reg_idx_t idx);
        logic hit;
        hit = (reg_kind(idx) != KIND_NONE);
        return hit;
    endfunction : is_mapped

    // Transfers wider than the 32-bit data bus are protocol errors and are ignored
    function automatic logic size_ok(input logic [2:0] size);
        return size <= 3'h2;
    endfunction : size_ok

    // Read view of one register, taken from a given state copy
    function automatic logic [7:0] read_byte(input regs_s s, input reg_idx_t idx);
        logic [7:0] v;
        int unsigned slot;
        v = 8'h00;
        slot = rsvd_slot(idx);
        unique case (reg_kind(idx))
            KIND_DLY_B3:
            begin
                v = s.dly_b3 & HIST_DLY_B3_WMASK; // [R2]
            end
            KIND_DLY_B2:
            begin
                v = s.dly_b2;
            end
            KIND_DLY_B1:
            begin
                v = s.dly_b1;
            end
            KIND_DLY_B0:
            begin
                v = s.dly_b0;
            end
            KIND_CHAN:
            begin
                v = {2'b00, s.chan_field}; // [R6]
            end
            KIND_PLL:
            begin
                v = {6'h00, s.pll_field}; // [R12]
            end
            KIND_RSVD:
            begin
                v = s.rsvd[slot] & RSVD_WMASK[slot];
            end
            KIND_NONE:
            begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction : read_byte

    // Address phase decode
    assign addr_ok = (i_haddr[31:14] == 18'h00000) && (i_haddr[1:0] == 2'b00) && size_ok(i_hsize);
    assign acc_idx = i_haddr[13:2];
    assign access = i_hsel && i_hready && ((i_htrans == HTRANS_NONSEQ) || (i_htrans == HTRANS_SEQ));

    // Data phase write commit
    // Kind of the register whose data phase is open
    assign wr_kind = reg_kind(q.wr_idx);
    assign wr_now = q.wr_pend && q.wr_map;
    assign chan_start = wr_now && (wr_kind == KIND_CHAN);
    assign pll_start[0] = wr_now && (wr_kind == KIND_PLL) && i_hwdata[PLL1_RST_BIT];
    assign pll_start[1] = wr_now && (wr_kind == KIND_PLL) && i_hwdata[PLL2_RST_BIT];

    always_comb
    begin
        int unsigned slot;
        slot = RSVD_NUM;
        d = q;

        // Writes land at the end of the data phase
        if (wr_now)
        begin
            slot = rsvd_slot(q.wr_idx);
            unique case (wr_kind)
                KIND_DLY_B3:
                begin
                    d.dly_b3 = i_hwdata[7:0] & HIST_DLY_B3_WMASK; // [R2]
                end
                KIND_DLY_B2:
                begin
                    d.dly_b2 = i_hwdata[7:0];
                end
                KIND_DLY_B1:
                begin
                    d.dly_b1 = i_hwdata[7:0];
                end
                KIND_DLY_B0:
                begin
                    d.dly_b0 = i_hwdata[7:0];
                end
                KIND_RSVD:
                begin
                    d.rsvd[slot] = i_hwdata[7:0] & RSVD_WMASK[slot];
                end
                KIND_CHAN, KIND_PLL, KIND_NONE:
                begin
                    // Soft reset fields are handled below
                end
            endcase
        end

        // Channel field: any write triggers, clear on done unless rewritten
        if (chan_start)
        begin
            d.chan_field = i_hwdata[CHAN_RST_W-1:0]; // [R6]
        end
        else if (chan_done)
        begin
            d.chan_field = CHAN_RST_RESET; // [R6] [R13]
        end

        // PLL bits: a write of one sets, the sequencer clears, set wins
        for (int unsigned p = 0; p < 2; p++)
        begin
            if (pll_start[p])
            begin
                d.pll_field[p] = 1'b1;
            end
            else if (pll_done[p])
            begin
                d.pll_field[p] = 1'b0; // [R10]
            end
            if (pll_done[p])
            begin
                d.ndiv_own[p] = 1'b1; // [R8] [R9]
            end
        end

        // Divider pulses come from the held code during the pulse window
        d.out_div_rst = chan_pulse ? chan_decode(q.chan_field) : '0; // [R5] [R13]
        d.pll_rst = pll_pulse; // [R7] [R9]

        // Capture the address phase
        d.wr_pend = access && i_hwrite;
        d.wr_idx = acc_idx;
        d.wr_map = addr_ok && is_mapped(acc_idx);

        // Read data sampled from the next state so a just-written value is seen
        if (access && !i_hwrite)
        begin
            d.rdata = (addr_ok && is_mapped(acc_idx)) ? {24'h000000, read_byte(d, acc_idx)} : 32'h00000000;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    reset_strobe_seq u_chan_seq
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(chan_start),
        .o_pulse(chan_pulse),
        .o_done(chan_done)
    );

    reset_strobe_seq u_pll1_seq
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(pll_start[0]),
        .o_pulse(pll_pulse[0]),
        .o_done(pll_done[0])
    );

    reset_strobe_seq u_pll2_seq
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(pll_start[1]),
        .o_pulse(pll_pulse[1]),
        .o_done(pll_done[1])
    );

    // Bus answers: zero wait states, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = q.rdata;

    assign o_second_loop_history_delay = {q.dly_b3[6:0], q.dly_b2, q.dly_b1, q.dly_b0}; // [R1]

    assign o_out_div_rst = q.out_div_rst;

    // The CMOS output divider has no reset port here, so it is never touched
    assign o_pll_cal_rst = q.pll_rst; // [R11]
    assign o_pll_ndiv_rst = q.pll_rst;
    assign o_pll_rdiv_rst = q.pll_rst;
    assign o_pll_vcodiv_rst = q.pll_rst;
    assign o_pll_ndiv_cal_own = q.ndiv_own;

endmodule : holdover_delay_and_soft_reset_regs

// ---- test/holdover_regs_chk.sv ----
// Concurrent checks on the ports of the holdover delay and soft reset slice
`timescale 1ns/100ps
module regs_slice_chk
    import clkgen_regs_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Bus
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    input wire logic [31:0] o_hrdata,
    // Setting and resets
    input wire logic [30:0] o_second_loop_history_delay,
    input wire logic [NUM_OUT_DIV-1:0] o_out_div_rst,
    input wire logic [1:0] o_pll_cal_rst,
    input wire logic [1:0] o_pll_ndiv_rst,
    input wire logic [1:0] o_pll_rdiv_rst,
    input wire logic [1:0] o_pll_vcodiv_rst,
    input wire logic [1:0] o_pll_ndiv_cal_own
);
    localparam logic [31:0] A_B3 = {18'h0, IDX_HIST_DLY_B3, 2'b00};
    localparam logic [31:0] A_B0 = {18'h0, IDX_HIST_DLY_B0, 2'b00};
    localparam logic [31:0] A_CH = {18'h0, IDX_CHAN_RST, 2'b00};
    localparam logic [31:0] A_PLL = {18'h0, IDX_PLL_RST, 2'b00};
    localparam logic [7:0] CH_MAP [8] = '{8'h01, 8'h02, 8'h0C, 8'h30, 8'h40, 8'h80, 8'h00, 8'h00};
    logic wr_q;
    logic rd_q;
    logic [31:0] adr_q;
    logic [7:0] exp_q;

    // Data phase tracking
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= 32'h0;
        end
        else if (i_hready)
        begin
            wr_q <= i_hsel & i_htrans[1] & i_hwrite;
            rd_q <= i_hsel & i_htrans[1] & ~i_hwrite;
            adr_q <= i_haddr;
        end
    end

    // Expected divider pattern of the last channel write
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            exp_q <= 8'h00;
        else if (wr_q && adr_q == A_CH)
            exp_q <= (i_hwdata[5:3] != 3'h0) ? 8'h00 : CH_MAP[i_hwdata[2:0]];
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_dly_low_byte: assert property (wr_q && adr_q == A_B0
        |=> o_second_loop_history_delay[7:0] == $past(i_hwdata[7:0]))
        else $error("delay low byte not taken");
    a_dly_top_byte: assert property (wr_q && adr_q == A_B3
        |=> o_second_loop_history_delay[30:24] == $past(i_hwdata[6:0]))
        else $error("delay top bits not taken");
    a_chan_rd_zero: assert property (rd_q && adr_q == A_CH |-> o_hrdata[31:6] == 26'h0)
        else $error("channel register upper bits not zero");
    a_pll_rd_zero: assert property (rd_q && adr_q == A_PLL |-> o_hrdata[31:2] == 30'h0)
        else $error("pll register upper bits not zero");
    a_chan_pulse: assert property (wr_q && adr_q == A_CH
        |-> ##2 (o_out_div_rst == exp_q) [*4] ##1 o_out_div_rst == 8'h00)
        else $error("channel divider pulse wrong");
    a_pll2_pulse: assert property (wr_q && adr_q == A_PLL && i_hwdata[1]
        |-> ##2 o_pll_cal_rst[1] [*4] ##1 !o_pll_cal_rst[1])
        else $error("second pll pulse wrong");
    a_pll_outs_same: assert property (o_pll_ndiv_rst == o_pll_cal_rst && o_pll_rdiv_rst == o_pll_cal_rst
        && o_pll_vcodiv_rst == o_pll_cal_rst)
        else $error("pll reset outputs differ");
    a_pll1_own: assert property (wr_q && adr_q == A_PLL && i_hwdata[0] |-> ##8 o_pll_ndiv_cal_own[0])
        else $error("first pll ownership not set");
    a_own_sticky: assert property (o_pll_ndiv_cal_own[1] |=> o_pll_ndiv_cal_own[1])
        else $error("second pll ownership dropped");
    a_pll_spares_out: assert property (|o_pll_cal_rst |-> o_out_div_rst == 8'h00)
        else $error("pll reset touched output dividers");
endmodule : regs_slice_chk

bind holdover_delay_and_soft_reset_regs regs_slice_chk i_regs_slice_chk (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata), .o_second_loop_history_delay(o_second_loop_history_delay),
    .o_out_div_rst(o_out_div_rst), .o_pll_cal_rst(o_pll_cal_rst), .o_pll_ndiv_rst(o_pll_ndiv_rst),
    .o_pll_rdiv_rst(o_pll_rdiv_rst), .o_pll_vcodiv_rst(o_pll_vcodiv_rst),
    .o_pll_ndiv_cal_own(o_pll_ndiv_cal_own));

// ---- test/holdover_delay_and_soft_reset_regs_tb.sv ----
// Self-checking testbench of the holdover delay and soft reset slice
`timescale 1ns/100ps
module holdover_delay_and_soft_reset_regs_tb;
    import clkgen_regs_pkg::*;
    localparam reg_idx_t MAP [6] = '{IDX_HIST_DLY_B3, IDX_HIST_DLY_B2, IDX_HIST_DLY_B1,
        IDX_HIST_DLY_B0, IDX_CHAN_RST, IDX_PLL_RST};
    localparam logic [7:0] DLY_VAL [4] = '{8'hBF, 8'hA5, 8'h5A, 8'h3C};
    localparam logic [7:0] CH_MAP [7] = '{8'h01, 8'h02, 8'h0C, 8'h30, 8'h40, 8'h80, 8'h00};
    logic clk, rst, hsel, hwrite, hresp, hreadyout;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [30:0] dly;
    logic [NUM_OUT_DIV-1:0] div_rst;
    logic [1:0] cal_rst, n_rst, r_rst, v_rst, own;
    int error_cnt = 0;
    int cmp_count = 0;
    int hits;

    holdover_delay_and_soft_reset_regs i_holdover_delay_and_soft_reset_regs (
        .i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout), .i_hwdata(hwdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
        .o_second_loop_history_delay(dly), .o_out_div_rst(div_rst), .o_pll_cal_rst(cal_rst),
        .o_pll_ndiv_rst(n_rst), .o_pll_rdiv_rst(r_rst), .o_pll_vcodiv_rst(v_rst),
        .o_pll_ndiv_cal_own(own));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    // One single AHB-Lite transfer, read data left in rd
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        check_val({31'h0, hresp}, 32'h0);
    endtask : xfer

    task automatic check_rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check_val(rd, exp);
    endtask : check_rd

    function automatic logic [31:0] adr(input reg_idx_t idx);
        return {18'h0, idx, 2'b00};
    endfunction : adr

    initial
    begin
        #200000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) check_rd(adr(MAP[i]), 32'h0);
        for (int i = 0; i < RSVD_NUM; i++)
        begin
            xfer(1'b1, adr(RSVD_IDX[i]), 32'hFF);
            check_rd(adr(RSVD_IDX[i]), {24'h0, RSVD_WMASK[i]});
            xfer(1'b1, adr(RSVD_IDX[i]), rd);
            check_rd(adr(RSVD_IDX[i]), {24'h0, RSVD_WMASK[i]});
        end
        for (int i = 0; i < 4; i++) xfer(1'b1, adr(MAP[i]), {24'h0, DLY_VAL[i]});
        check_rd(adr(IDX_HIST_DLY_B3), 32'h3F);
        check_val({1'b0, dly}, 32'h3FA55A3C);
        // Misaligned, out of range and unmapped writes change nothing
        xfer(1'b1, adr(IDX_HIST_DLY_B3) + 32'h1, 32'h0);
        xfer(1'b1, adr(IDX_HIST_DLY_B3) | 32'h0001_0000, 32'h0);
        xfer(1'b1, adr(12'h288), 32'h55);
        check_rd(adr(12'h288), 32'h0);
        check_rd(adr(IDX_HIST_DLY_B3), 32'h3F);
        for (int c = 0; c < 7; c++)
        begin
            xfer(1'b1, adr(IDX_CHAN_RST), c);
            hits = 0;
            // Count pulse cycles from the committing edge, mid-cycle where settled
            fork
                check_rd(adr(IDX_CHAN_RST), c);
                repeat (8)
                begin
                    @(negedge clk);
                    hits += int'(div_rst === CH_MAP[c]);
                end
            join
            @(posedge clk);
            check_val(hits, (c < 6) ? 4 : 8);
            check_rd(adr(IDX_CHAN_RST), 32'h0);
        end
        for (int p = 0; p < 2; p++)
        begin
            xfer(1'b1, adr(IDX_PLL_RST), 32'hFC | (32'h1 << p));
            hits = 0;
            fork
                check_rd(adr(IDX_PLL_RST), 32'h1 << p);
                repeat (8)
                begin
                    @(negedge clk);
                    hits += int'(cal_rst === 2'(1 << p) && n_rst === cal_rst && r_rst === cal_rst
                        && v_rst === cal_rst && div_rst === 8'h00);
                end
            join
            @(posedge clk);
            check_val(hits, 4);
            check_rd(adr(IDX_PLL_RST), 32'h0);
            check_val({30'h0, own}, p ? 32'h3 : 32'h1);
        end
        // Second reset in mid-run
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_val({30'h0, own}, 32'h0);
        check_rd(adr(IDX_HIST_DLY_B0), 32'h0);
        end_of_test();
    end
endmodule : holdover_delay_and_soft_reset_regs_tb
